// [hdl/vipu_map.svh]
`ifndef VIPU_MAP_SVH
`define VIPU_MAP_SVH

// Register indices; the byte address on the bus is four times the index.
`define IDX_REQ_FLAGS0_LOW   16'hFFE0
`define IDX_REQ_FLAGS0_HIGH  16'hFFE1
`define IDX_REQ_FLAGS1_LOW   16'hFFE2
`define IDX_REQ_FLAGS1_HIGH  16'hFFE3
`define IDX_MASK_FLAGS0_LOW  16'hFFE4
`define IDX_MASK_FLAGS0_HIGH 16'hFFE5
`define IDX_MASK_FLAGS1_LOW  16'hFFE6
`define IDX_PRIO_FLAGS0_LOW  16'hFFE8
`define IDX_PRIO_FLAGS0_HIGH 16'hFFE9
`define IDX_PRIO_FLAGS1_LOW  16'hFFEA
`define IDX_SERVICE_STATUS   16'hFFEB
`define IDX_RISING_EDGE_EN   16'hFF48
`define IDX_FALLING_EDGE_EN  16'hFF49
`define IDX_LOW_VOLTAGE_MODE 16'hFFBE

// Bit positions inside the registers.
`define LVI_RESET_SEL_BIT    1
`define REQ1_RESUME_BIT      0
`define REQ1_TIMER8B_BIT     3

// Reset values.
`define RST_REQ_FLAGS        18'h00000
`define RST_MASK_FLAGS       18'h3FFFF
`define RST_PRIO_FLAGS       18'h3FFFF
`define RST_EDGE_EN          4'h0

// Source counts and vector addresses.
`define NUM_EXT_PINS         4
`define NUM_INT_SOURCES      14
`define NUM_MASKABLE         18
`define LAST_SRC_IDX         5'h11
`define VEC_BASE             16'h0004
`define VEC_LAST             16'h002A
`define VEC_BREAK            16'h003E
`define VEC_RESET            16'h0000

`endif

// [hdl/vipu_pkg.sv]
package vipu_pkg;
  typedef logic [17:0] src_vec_t;
  typedef logic [15:0] vector_addr_t;
  typedef logic [4:0]  src_idx_t;
  typedef logic [31:0] bus_word_t;
  typedef logic [17:0] bus_addr_t;
endpackage : vipu_pkg

// [hdl/edge_if.sv]
`timescale 1ns/1ps
interface edge_if;
  logic [3:0] rise;
  logic [3:0] fall;
  modport source (output rise, output fall);
  modport sink   (input rise, input fall);
endinterface : edge_if

// [hdl/ext_pin_edge.sv]
`timescale 1ns/1ps
module ext_pin_edge #(
  parameter int NUM_PINS = 4
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  input  wire logic [NUM_PINS-1:0] pins,
  input  wire logic [NUM_PINS-1:0] risingEdgeEnable,
  input  wire logic [NUM_PINS-1:0] fallingEdgeEnable,
  edge_if.source                   edges
);
  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++) begin : g_pin
      logic [2:0] sync;
      logic       level;
      logic       risePulse;
      logic       fallPulse;
      logic       next_level;
      logic       next_rise;
      logic       next_fall;

      // A change is accepted only once the second and third stages agree.
      always_comb begin
        next_level = level;
        next_rise  = 1'b0;
        next_fall  = 1'b0;
        if (sync[1] == sync[2]) begin
          next_level = sync[2];
          next_rise  = ~level & sync[2] & risingEdgeEnable[i];
          next_fall  = level & ~sync[2] & fallingEdgeEnable[i];
        end
      end

      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          sync      <= 3'h0;
          level     <= 1'b0;
          risePulse <= 1'b0;
          fallPulse <= 1'b0;
        end else begin
          sync      <= {sync[1:0], pins[i]};
          level     <= next_level;
          risePulse <= next_rise;
          fallPulse <= next_fall;
        end
      end

      assign edges.rise[i] = risePulse;
      assign edges.fall[i] = fallPulse;
    end
  endgenerate
endmodule : ext_pin_edge

// [hdl/vectored_interrupt_priority_unit.sv]
// The implementer's own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "vipu_map.svh"
// Operation
// - Each maskable source is blocked by its own mask flag.
// - Priority flag bit puts each source in high or low group.
// - Unmasked high-group request may interrupt low-group service.
// - Equal-priority simultaneous requests are resolved by fixed default order.
// - Default priority numbers 0 to 18; smaller number wins.
// - Any unmasked pending request releases stop and halt modes.
// - Four external pin requests and fourteen internal requests.
// - Break instruction raises software interrupt at 003EH, even when disabled.
// - Software interrupt bypasses group and default-order arbitration.
// - Nineteen interrupt sources; reset sources vector to 0000H.
// - Pins 0..3 use priorities 1..4, vectors 0006H..000CH.
// - Low-voltage interrupt at 0004H only when reset select bit is 0.
// - USB status 0,1,2 vector 000EH, 0010H, 001CH; priorities 5,6,12.
// - Serial sources vector 0012H, 0014H, 0016H and 0018H.
// - 8-bit timer matches vector 001AH, 001EH; second timer 002AH, priority 18.
// - 16-bit timer channels vector 0020H and 0022H.
// - USB resume request has priority 16, vector 0024H.
// - Acknowledge clears the chosen source's request flag.
// - Request flags reset to zero.
// - Pins detect rising and falling edges under separate enables.
module vectored_interrupt_priority_unit (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire vipu_pkg::bus_addr_t    paddr,
  input  wire vipu_pkg::bus_word_t    pwdata,
  output vipu_pkg::bus_word_t         prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [3:0]             extPinIrq,
  input  wire logic                   lowVoltageIrq,
  input  wire logic                   usbStatus0Irq,
  input  wire logic                   usbStatus1Irq,
  input  wire logic                   usbStatus2Irq,
  input  wire logic                   asyncRxErrorIrq,
  input  wire logic                   asyncRxDoneIrq,
  input  wire logic                   asyncTxDoneIrq,
  input  wire logic                   clockedSerialDoneIrq,
  input  wire logic                   timerHMatchIrq,
  input  wire logic                   timer8AMatchIrq,
  input  wire logic                   timer16Ch0Irq,
  input  wire logic                   timer16Ch1Irq,
  input  wire logic                   usbResumeIrq,
  input  wire logic                   timer8BMatchIrq,
  input  wire logic                   breakInstruction,
  input  wire logic                   intEnable,
  input  wire logic                   intAck,
  input  wire logic                   intReturn,
  output logic                        intReq,
  output vipu_pkg::vector_addr_t      intVector,
  output logic                        intHighPrio,
  output logic                        standbyRelease,
  output logic                        lowVoltageResetReq
);
  import vipu_pkg::*;

  src_vec_t     reqFlags;
  src_vec_t     maskFlags;
  src_vec_t     prioFlags;
  logic [3:0]   risingEdgeEnable;
  logic [3:0]   fallingEdgeEnable;
  logic         lowVoltageResetSelect;
  logic         lowActive;
  logic         highActive;
  logic         brkPending;
  logic         winnerBrk;
  src_idx_t     winnerIdx;

  src_vec_t     next_reqFlags;
  src_vec_t     next_maskFlags;
  src_vec_t     next_prioFlags;
  logic [3:0]   next_risingEdgeEnable;
  logic [3:0]   next_fallingEdgeEnable;
  logic         next_lowVoltageResetSelect;
  logic         next_lowActive;
  logic         next_highActive;
  logic         next_brkPending;
  logic         next_winnerBrk;
  src_idx_t     next_winnerIdx;
  logic         next_intReq;
  vector_addr_t next_intVector;
  logic         next_intHighPrio;
  logic         next_standbyRelease;
  logic         next_lowVoltageResetReq;
  bus_word_t    next_prdata;
  logic         next_pslverr;

  src_vec_t     hwSet;
  src_vec_t     candidates;
  src_vec_t     highCandidates;
  src_vec_t     pool;
  logic         ackTake;
  logic         wrTake;
  logic         setupPhase;
  bus_word_t    rdData;
  logic         rdHit;
  logic [15:0]  regIdx;

  edge_if pinEdge ();

  ext_pin_edge #(
    .NUM_PINS          (`NUM_EXT_PINS)
  ) u_pin_edge (
    .mclk              (mclk),
    .rst_n             (rst_n),
    .pins              (extPinIrq),
    .risingEdgeEnable  (risingEdgeEnable),
    .fallingEdgeEnable (fallingEdgeEnable),
    .edges             (pinEdge.source)
  );

  // Vector of a maskable source from its flag index, which equals its default priority,
  // except the last source that sits past the two empty slots.
  function automatic vector_addr_t vectorOf(input src_idx_t idx);
    if (idx == `LAST_SRC_IDX) begin
      vectorOf = `VEC_LAST;
    end else begin
      vectorOf = `VEC_BASE + {10'h000, idx, 1'b0};
    end
  endfunction : vectorOf

  // Flag bit i carries default priority i (bit 17 carries 18), so no source ever holds 17.
  always_comb begin
    hwSet = {timer8BMatchIrq, usbResumeIrq,
             timer16Ch1Irq, timer16Ch0Irq,
             timer8AMatchIrq, usbStatus2Irq, timerHMatchIrq,
             clockedSerialDoneIrq, asyncTxDoneIrq, asyncRxDoneIrq,
             asyncRxErrorIrq,
             usbStatus1Irq, usbStatus0Irq,
             pinEdge.rise | pinEdge.fall,
             lowVoltageIrq & ~lowVoltageResetSelect};
  end

  assign setupPhase = psel & ~penable;
  assign pready     = penable;
  assign wrTake     = psel & penable & pwrite;
  assign ackTake    = intAck & intReq;
  assign regIdx     = paddr[17:2];

  always_comb begin
    rdData = 32'h0000_0000;
    rdHit  = (paddr[1:0] == 2'h0);
    case (regIdx)
      `IDX_REQ_FLAGS0_LOW:   rdData[7:0] = reqFlags[7:0];
      `IDX_REQ_FLAGS0_HIGH:  rdData[7:0] = reqFlags[15:8];
      `IDX_REQ_FLAGS1_LOW:   rdData[7:0] = {4'h0, reqFlags[17], 2'h0, reqFlags[16]};
      `IDX_REQ_FLAGS1_HIGH:  rdData[7:0] = 8'h00;
      `IDX_MASK_FLAGS0_LOW:  rdData[7:0] = maskFlags[7:0];
      `IDX_MASK_FLAGS0_HIGH: rdData[7:0] = maskFlags[15:8];
      `IDX_MASK_FLAGS1_LOW:  rdData[7:0] = {4'h0, maskFlags[17], 2'h0, maskFlags[16]};
      `IDX_PRIO_FLAGS0_LOW:  rdData[7:0] = prioFlags[7:0];
      `IDX_PRIO_FLAGS0_HIGH: rdData[7:0] = prioFlags[15:8];
      `IDX_PRIO_FLAGS1_LOW:  rdData[7:0] = {4'h0, prioFlags[17], 2'h0, prioFlags[16]};
      `IDX_SERVICE_STATUS:   rdData[7:0] = {5'h00, brkPending, highActive, lowActive};
      `IDX_RISING_EDGE_EN:   rdData[7:0] = {4'h0, risingEdgeEnable};
      `IDX_FALLING_EDGE_EN:  rdData[7:0] = {4'h0, fallingEdgeEnable};
      `IDX_LOW_VOLTAGE_MODE: rdData[`LVI_RESET_SEL_BIT] = lowVoltageResetSelect;
      default:               rdHit = 1'b0;
    endcase
  end

  always_comb begin
    next_reqFlags              = reqFlags;
    next_maskFlags             = maskFlags;
    next_prioFlags             = prioFlags;
    next_risingEdgeEnable      = risingEdgeEnable;
    next_fallingEdgeEnable     = fallingEdgeEnable;
    next_lowVoltageResetSelect = lowVoltageResetSelect;
    next_lowActive             = lowActive;
    next_highActive            = highActive;
    next_brkPending            = brkPending;
    next_prdata                = prdata;
    next_pslverr               = pslverr;

    // Read data and the error answer are prepared in the setup cycle.
    if (setupPhase) begin
      next_prdata  = rdHit ? rdData : 32'h0000_0000;
      next_pslverr = ~rdHit;
    end

    if (wrTake && rdHit) begin
      case (regIdx)
        `IDX_REQ_FLAGS0_LOW:   next_reqFlags[7:0]    = pwdata[7:0];
        `IDX_REQ_FLAGS0_HIGH:  next_reqFlags[15:8]   = pwdata[7:0];
        `IDX_REQ_FLAGS1_LOW: begin
          next_reqFlags[16] = pwdata[`REQ1_RESUME_BIT];
          next_reqFlags[17] = pwdata[`REQ1_TIMER8B_BIT];
        end
        `IDX_MASK_FLAGS0_LOW:  next_maskFlags[7:0]   = pwdata[7:0];
        `IDX_MASK_FLAGS0_HIGH: next_maskFlags[15:8]  = pwdata[7:0];
        `IDX_MASK_FLAGS1_LOW: begin
          next_maskFlags[16] = pwdata[`REQ1_RESUME_BIT];
          next_maskFlags[17] = pwdata[`REQ1_TIMER8B_BIT];
        end
        `IDX_PRIO_FLAGS0_LOW:  next_prioFlags[7:0]   = pwdata[7:0];
        `IDX_PRIO_FLAGS0_HIGH: next_prioFlags[15:8]  = pwdata[7:0];
        `IDX_PRIO_FLAGS1_LOW: begin
          next_prioFlags[16] = pwdata[`REQ1_RESUME_BIT];
          next_prioFlags[17] = pwdata[`REQ1_TIMER8B_BIT];
        end
        `IDX_RISING_EDGE_EN:   next_risingEdgeEnable  = pwdata[3:0];
        `IDX_FALLING_EDGE_EN:  next_fallingEdgeEnable = pwdata[3:0];
        `IDX_LOW_VOLTAGE_MODE: next_lowVoltageResetSelect = pwdata[`LVI_RESET_SEL_BIT];
        default: ;
      endcase
    end

    if (ackTake) begin
      if (winnerBrk) begin
        next_brkPending = 1'b0;
      end else begin
        next_reqFlags[winnerIdx] = 1'b0;
        if (intHighPrio) begin
          next_highActive = 1'b1;
        end else begin
          next_lowActive = 1'b1;
        end
      end
    end else if (intReturn) begin
      if (highActive) begin
        next_highActive = 1'b0;
      end else begin
        next_lowActive = 1'b0;
      end
    end

    // Hardware events are merged last so that they survive a clear in the same cycle.
    next_reqFlags = next_reqFlags | hwSet;
    if (breakInstruction) begin
      next_brkPending = 1'b1;
    end
  end

  // Arbitration looks at the state after this edge, so an acknowledged request is
  // withdrawn in the very next cycle instead of lingering one cycle stale.
  always_comb begin
    candidates     = next_reqFlags & ~next_maskFlags;
    highCandidates = candidates & ~next_prioFlags;
    if (next_highActive || !intEnable) begin
      pool = '0;
    end else if (next_lowActive || (|highCandidates)) begin
      pool = highCandidates;
    end else begin
      pool = candidates;
    end
    next_winnerIdx = winnerIdx;
    for (int i = `NUM_MASKABLE - 1; i >= 0; i--) begin
      if (pool[i]) begin
        next_winnerIdx = src_idx_t'(i);
      end
    end
    next_winnerBrk   = next_brkPending;
    next_intReq      = next_brkPending | (|pool);
    next_intHighPrio = 1'b0;
    next_intVector   = intVector;
    if (next_brkPending) begin
      next_intVector = `VEC_BREAK;
    end else if (|pool) begin
      next_intVector   = vectorOf(next_winnerIdx);
      next_intHighPrio = ~next_prioFlags[next_winnerIdx];
    end
    next_standbyRelease     = |candidates;
    next_lowVoltageResetReq = lowVoltageIrq & lowVoltageResetSelect;
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reqFlags              <= `RST_REQ_FLAGS;
      maskFlags             <= `RST_MASK_FLAGS;
      prioFlags             <= `RST_PRIO_FLAGS;
      risingEdgeEnable      <= `RST_EDGE_EN;
      fallingEdgeEnable     <= `RST_EDGE_EN;
      lowVoltageResetSelect <= 1'b0;
      lowActive             <= 1'b0;
      highActive            <= 1'b0;
      brkPending            <= 1'b0;
      winnerBrk             <= 1'b0;
      winnerIdx             <= 5'h00;
      intReq                <= 1'b0;
      intVector             <= `VEC_RESET;
      intHighPrio           <= 1'b0;
      standbyRelease        <= 1'b0;
      lowVoltageResetReq    <= 1'b0;
      prdata                <= 32'h0000_0000;
      pslverr               <= 1'b0;
    end else begin
      reqFlags              <= next_reqFlags;
      maskFlags             <= next_maskFlags;
      prioFlags             <= next_prioFlags;
      risingEdgeEnable      <= next_risingEdgeEnable;
      fallingEdgeEnable     <= next_fallingEdgeEnable;
      lowVoltageResetSelect <= next_lowVoltageResetSelect;
      lowActive             <= next_lowActive;
      highActive            <= next_highActive;
      brkPending            <= next_brkPending;
      winnerBrk             <= next_winnerBrk;
      winnerIdx             <= next_winnerIdx;
      intReq                <= next_intReq;
      intVector             <= next_intVector;
      intHighPrio           <= next_intHighPrio;
      standbyRelease        <= next_standbyRelease;
      lowVoltageResetReq    <= next_lowVoltageResetReq;
      prdata                <= next_prdata;
      pslverr               <= next_pslverr;
    end
  end
endmodule : vectored_interrupt_priority_unit

// [tb/vipu_checker_asserts.sv]
`timescale 1ns/1ps
module vipu_checker (
  input wire logic                   mclk,
  input wire logic                   rst_n,
  input wire logic                   intEnable,
  input wire logic                   intAck,
  input wire logic                   breakInstruction,
  input wire logic                   lowVoltageIrq,
  input wire logic                   timer8BMatchIrq,
  input wire logic                   intReq,
  input wire vipu_pkg::vector_addr_t intVector,
  input wire logic                   intHighPrio,
  input wire logic                   standbyRelease,
  input wire logic                   lowVoltageResetReq
);
  import vipu_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  break_first_a: assert property (
    breakInstruction && !intAck |=> intReq && intVector == 16'h003E)
    else $error("break request not presented at its vector");
  vec_gap_a: assert property (
    intReq |-> intVector != 16'h0026 && intVector != 16'h0028
               && (intVector <= 16'h002A || intVector == 16'h003E))
    else $error("vector outside the used slots");
  vec_even_a: assert property (intReq |-> !intVector[0] && intVector >= 16'h0004)
    else $error("odd or reset vector presented");
  standby_wake_a: assert property (intReq && intVector != 16'h003E |-> standbyRelease)
    else $error("maskable request without standby release");
  gie_gate_a: assert property (!intEnable |=> !intReq || intVector == 16'h003E)
    else $error("maskable request presented while disabled");
  ack_clear_a: assert property (
    intAck && intReq && intVector == 16'h002A && !timer8BMatchIrq
    |=> !(intReq && intVector == 16'h002A))
    else $error("acknowledged request presented again");
  reset_quiet_a: assert property (
    $rose(rst_n) |-> !intReq && !standbyRelease && !lowVoltageResetReq)
    else $error("outputs active right after reset");
  lvi_reset_a: assert property (lowVoltageResetReq |-> $past(lowVoltageIrq))
    else $error("reset request without low voltage event");
  cover property (intAck && intReq && intHighPrio);
  cover property (intAck && intReq && intVector == 16'h003E);
  cover property (lowVoltageResetReq);
endmodule : vipu_checker
bind vectored_interrupt_priority_unit vipu_checker chk (
  .mclk, .rst_n, .intEnable, .intAck, .breakInstruction, .lowVoltageIrq, .timer8BMatchIrq,
  .intReq, .intVector, .intHighPrio, .standbyRelease, .lowVoltageResetReq);

// [tb/cpu_core_model.sv]
`timescale 1ns/1ps
module cpu_core_model (
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  input  wire logic                   gie,
  input  var  int                     ackDelay,
  input  var  int                     serviceLen,
  input  wire logic                   intReq,
  input  wire vipu_pkg::vector_addr_t intVector,
  output logic                        intEnable,
  output logic                        intAck,
  output logic                        intReturn
);
  import vipu_pkg::*;
  int waited;
  int depth;
  int timer;
  // Routines retire one at a time, so a nested routine always leaves before the one it broke into.
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      intEnable <= 1'b0;
      intAck <= 1'b0;
      intReturn <= 1'b0;
      waited = 0;
      depth = 0;
      timer = 0;
    end else begin
      intEnable <= gie;
      intAck <= 1'b0;
      intReturn <= 1'b0;
      if (intAck && intReq && intVector != 16'h003E) begin
        depth++;
        timer = serviceLen;
      end
      if (intReq && !intAck) begin
        if (waited >= ackDelay) begin
          intAck <= 1'b1;
          waited = 0;
        end else waited++;
      end else if (timer > 0) timer--;
      else if (depth > 0) begin
        intReturn <= 1'b1;
        depth--;
        timer = serviceLen;
      end
    end
  end
endmodule : cpu_core_model

// [tb/vectored_interrupt_priority_unit_tb.sv]
`timescale 1ns/1ps
`include "vipu_map.svh"
module vectored_interrupt_priority_unit_tb;
  import vipu_pkg::*;
  logic         mclk = 1'b0;
  logic         rst_n = 1'b0;
  logic         psel = 1'b0;
  logic         penable = 1'b0;
  logic         pwrite = 1'b0;
  logic         gie = 1'b1;
  logic         breakInstruction = 1'b0;
  logic         lviSeen = 1'b0;
  logic [3:0]   extPinIrq = 4'h0;
  logic [17:0]  ev = 18'h00000;
  bus_addr_t    paddr = 18'h00000;
  bus_word_t    pwdata = 32'h00000000;
  bus_word_t    prdata;
  vector_addr_t intVector;
  vector_addr_t expV, hiVec = 16'hFFFF;
  logic         pready, intReq, standbyRelease, lowVoltageResetReq, intEnable, intAck, intReturn;
  logic         pslverr, intHighPrio;
  int           ackDelay = 0, serviceLen = 6, errors = 0, num_checks = 0, seed = 88;
  vector_addr_t vecQ[$];
  bus_word_t    rdQ[$];
  always #4 mclk = ~mclk;
  vectored_interrupt_priority_unit uut (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .extPinIrq, .lowVoltageIrq(ev[0]), .usbStatus0Irq(ev[5]),
    .usbStatus1Irq(ev[6]), .asyncRxErrorIrq(ev[7]), .asyncRxDoneIrq(ev[8]),
    .asyncTxDoneIrq(ev[9]), .clockedSerialDoneIrq(ev[10]), .timerHMatchIrq(ev[11]),
    .usbStatus2Irq(ev[12]), .timer8AMatchIrq(ev[13]), .timer16Ch0Irq(ev[14]),
    .timer16Ch1Irq(ev[15]), .usbResumeIrq(ev[16]), .timer8BMatchIrq(ev[17]),
    .breakInstruction, .intEnable, .intAck, .intReturn, .intReq, .intVector,
    .intHighPrio, .standbyRelease, .lowVoltageResetReq);
  cpu_core_model cpu (.mclk, .rst_n, .gie, .ackDelay, .serviceLen, .intReq, .intVector,
    .intEnable, .intAck, .intReturn);
  task automatic check(input string what, input bus_word_t exp, input bus_word_t got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // Results are compared where they appear, against the oldest expectation noted by the driver.
  always @(posedge mclk) begin
    if (intAck === 1'b1 && intReq === 1'b1) begin
      expV = (vecQ.size() == 0) ? 16'hFFFF : vecQ.pop_front();
      check("vector", {16'h0000, expV}, {16'h0000, intVector});
      check("high group", {31'h0, expV == hiVec}, {31'h0, intHighPrio});
    end
    if (psel && penable && pready === 1'b1 && !pwrite && rdQ.size() > 0)
      check("read data", rdQ.pop_front(), prdata);
    if (lowVoltageResetReq === 1'b1) lviSeen <= 1'b1;
  end
  task automatic apb(input logic wr, input logic [15:0] idx, input bus_word_t d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) check("bus timeout", 32'h0, 32'h1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [15:0] idx, input logic [7:0] e);
    rdQ.push_back({24'h000000, e});
    apb(1'b0, idx, 32'h00000000);
  endtask : rd
  task automatic wr3(input logic [15:0] base, input logic [17:0] v);
    apb(1'b1, base, {24'h000000, v[7:0]});
    apb(1'b1, base + 16'h0001, {24'h000000, v[15:8]});
    apb(1'b1, base + 16'h0002, {28'h0000000, v[17], 2'b00, v[16]});
  endtask : wr3
  task automatic fire(input logic [17:0] m);
    @(posedge mclk);
    ev <= m;
    @(posedge mclk);
    ev <= 18'h00000;
  endtask : fire
  task automatic settle();
    int n;
    n = 0;
    while ((vecQ.size() != 0 || cpu.depth != 0 || intReq === 1'b1) && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    if (n >= 3000) check("settle timeout", 32'h0, 32'h1);
  endtask : settle
  function automatic vector_addr_t expVec(input int i);
    return (i == 17) ? 16'h002A : 16'h0004 + 16'(2 * i);
  endfunction : expVec
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    end_of_test();
  end
  initial begin
    logic [17:0] m;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    rd(`IDX_REQ_FLAGS0_HIGH, 8'h00);
    rd(`IDX_MASK_FLAGS0_LOW, 8'hFF);
    rd(`IDX_PRIO_FLAGS0_HIGH, 8'hFF);
    rd(16'hFF00, 8'h00);
    check("slave error", 32'h1, {31'h0, pslverr});
    fire(18'h00020);
    rd(`IDX_REQ_FLAGS0_LOW, 8'h20);
    check("masked request", 32'h0, {31'h0, intReq});
    vecQ.push_back(16'h000E);
    wr3(`IDX_MASK_FLAGS0_LOW, 18'h00000);
    settle();
    rd(`IDX_REQ_FLAGS0_LOW, 8'h00);
    $display("test reset and mask done");
    ackDelay <= 5;
    for (int i = 0; i < 18; i++) begin
      if (i >= 1 && i <= 4) continue;
      serviceLen <= 4 + {$random(seed)} % 4;
      vecQ.push_back(expVec(i));
      fire(18'h00001 << i);
      settle();
    end
    ackDelay <= 0;
    $display("test single sources done");
    repeat (6) begin
      ackDelay <= {$random(seed)} % 4;
      m = 18'($random(seed)) & 18'h3FFE1;
      for (int i = 0; i < 18; i++) if (m[i]) vecQ.push_back(expVec(i));
      fire(m);
      settle();
    end
    $display("test simultaneous done");
    wr3(`IDX_PRIO_FLAGS0_LOW, 18'h1FFFF);
    hiVec = 16'h002A;
    vecQ.push_back(16'h002A);
    vecQ.push_back(16'h000E);
    fire(18'h20020);
    settle();
    serviceLen <= 40;
    vecQ.push_back(16'h000E);
    vecQ.push_back(16'h002A);
    fire(18'h00020);
    repeat (10) @(posedge mclk);
    fire(18'h20000);
    settle();
    serviceLen <= 6;
    $display("test groups and nesting done");
    gie <= 1'b0;
    vecQ.push_back(16'h003E);
    fire(18'h00020);
    breakInstruction <= 1'b1;
    @(posedge mclk);
    breakInstruction <= 1'b0;
    settle();
    check("standby release", 32'h1, {31'h0, standbyRelease});
    vecQ.push_back(16'h000E);
    gie <= 1'b1;
    settle();
    $display("test break done");
    apb(1'b1, `IDX_RISING_EDGE_EN, 32'h0000000F);
    for (int p = 0; p < 4; p++) begin
      vecQ.push_back(expVec(p + 1));
      @(posedge mclk);
      extPinIrq <= extPinIrq | (4'h1 << p);
      settle();
    end
    apb(1'b1, `IDX_RISING_EDGE_EN, 32'h00000000);
    apb(1'b1, `IDX_FALLING_EDGE_EN, 32'h00000004);
    vecQ.push_back(16'h000A);
    extPinIrq <= 4'h0;
    settle();
    rd(`IDX_REQ_FLAGS0_LOW, 8'h00);
    $display("test pins done");
    apb(1'b1, `IDX_LOW_VOLTAGE_MODE, 32'h00000002);
    lviSeen = 1'b0;
    fire(18'h00001);
    repeat (3) @(posedge mclk);
    check("low voltage reset", 32'h1, {31'h0, lviSeen});
    rd(`IDX_REQ_FLAGS0_LOW, 8'h00);
    $display("test low voltage reset done");
    end_of_test();
  end
endmodule : vectored_interrupt_priority_unit_tb
